// ### design/fai_pkg.sv
package fai_pkg;
  localparam int NUM_CH    = 4;
  localparam int IMG_BYTES = 8;
  localparam int PRM_BYTES = 10;
  localparam logic [3:0] PRM_FN_LAST = 4'h3;
  localparam logic [3:0] PRM_LAST    = 4'h9;

  localparam logic [7:0] FN_KEEP    = 8'h00;
  localparam logic [7:0] FN_OFF     = 8'hff;
  localparam logic [7:0] FN_DEFAULT = 8'h28;
  localparam logic [7:0] FN_RTD2_LO = 8'h01;
  localparam logic [7:0] FN_RTD2_HI = 8'h04;
  localparam logic [7:0] FN_RES2_LO = 8'h05;
  localparam logic [7:0] FN_RES2_HI = 8'h08;
  localparam logic [7:0] FN_RTD4_LO = 8'h09;
  localparam logic [7:0] FN_RTD4_HI = 8'h0c;
  localparam logic [7:0] FN_RES4_LO = 8'h0d;
  localparam logic [7:0] FN_RES4_HI = 8'h0f;
  localparam logic [7:0] FN_TCE_LO  = 8'h10;
  localparam logic [7:0] FN_TCE_HI  = 8'h15;
  localparam logic [7:0] FN_TCI_LO  = 8'h18;
  localparam logic [7:0] FN_TCI_HI  = 8'h1d;
  localparam logic [7:0] FN_MV50    = 8'h27;
  localparam logic [7:0] FN_S7_LO   = 8'h28;
  localparam logic [7:0] FN_S7_HI   = 8'h2a;
  localparam logic [7:0] FN_S5_V10  = 8'h2b;

  localparam logic [15:0] RES_RESET = 16'h0000;
  localparam logic [15:0] S7_POS    = 16'h7fff;
  localparam logic [15:0] S7_NEG    = 16'h8001;
  localparam logic [15:0] S5_LIM    = 16'h5000;
  localparam logic [15:0] S5_MUL    = 16'h4bda;
  localparam int          S5_SHIFT  = 15;

  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned BLINK_MS   = 250;
  localparam int unsigned BLINK_CYC  = CLK_HZ / 1000 * BLINK_MS;
  localparam int          BLINK_W    = 23;
  localparam logic [BLINK_W-1:0] BLINK_RESET = 23'h000000;

  typedef enum logic [2:0] {
    FAI_ST_RD  = 3'b001,
    FAI_ST_CAP = 3'b010,
    FAI_ST_RUN = 3'b100
  } fai_st_type;

  function automatic logic fai_fn_valid(input logic [7:0] c);
    return (c >= FN_RTD2_LO && c <= FN_TCE_HI) || (c >= FN_TCI_LO && c <= FN_TCI_HI) ||
           (c >= FN_MV50 && c <= FN_S5_V10);
  endfunction
endpackage

// ### design/fai_ch_if.sv
`timescale 1ns/1ps
interface fai_ch_if;
  logic        [7:0]  code;
  logic               smp_vld;
  logic signed [15:0] smp;
  logic        [15:0] result;
  logic               open_det;
  logic               over_det;
  logic               blink;
  logic               lamp;
  modport top (output code, smp_vld, smp, open_det, over_det, blink, input result, lamp);
  modport fmt (input code, smp_vld, smp, output result);
  modport lmp (input code, open_det, over_det, blink, output lamp);
endinterface

// ### design/fai_fmt.sv
`timescale 1ns/1ps
module fai_fmt (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  fai_ch_if.fmt     ch
);
  typedef struct packed {
    logic [15:0] res;
  } fai_fmt_st_type;

  fai_fmt_st_type st_ff;
  fai_fmt_st_type nxt_st;

  localparam logic [16:0] S5_MULW = {1'b0, fai_pkg::S5_MUL};

  always_comb begin
    logic [16:0] mag;
    logic [32:0] prod;
    logic [17:0] sc;
    mag    = '0;
    prod   = '0;
    sc     = '0;
    nxt_st = st_ff;
    mag    = ch.smp[15] ? 17'(-$signed({ch.smp[15], ch.smp})) : {1'b0, ch.smp};
    // widen before the product, a 17 bit product would lose the top
    prod   = {16'h0000, mag} * {16'h0000, S5_MULW};
    sc     = 18'(prod >> fai_pkg::S5_SHIFT);
    if (ch.code == fai_pkg::FN_OFF) begin
      nxt_st.res = fai_pkg::RES_RESET;
    end else if (ch.smp_vld) begin
      nxt_st.res = ch.smp;
      if ((ch.code >= fai_pkg::FN_RES2_LO && ch.code <= fai_pkg::FN_RES2_HI) ||
          (ch.code >= fai_pkg::FN_RES4_LO && ch.code <= fai_pkg::FN_RES4_HI)) begin
        if (ch.smp[15]) begin
          nxt_st.res = fai_pkg::RES_RESET;
        end
      end else if (ch.code >= fai_pkg::FN_MV50 && ch.code <= fai_pkg::FN_S7_HI) begin
        if (ch.smp == 16'h8000) begin
          nxt_st.res = fai_pkg::S7_NEG;
        end
      end else if (ch.code == fai_pkg::FN_S5_V10) begin
        if (sc > {2'b00, fai_pkg::S5_LIM}) begin
          sc = {2'b00, fai_pkg::S5_LIM};
        end
        nxt_st.res = {ch.smp[15] && (sc != '0), sc[14:0]};
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '{res: fai_pkg::RES_RESET};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ch.result = st_ff.res;
endmodule

// ### design/fai_lamp.sv
`timescale 1ns/1ps
module fai_lamp (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  fai_ch_if.lmp     ch
);
  typedef struct packed {
    logic lamp;
  } fai_lamp_st_type;

  fai_lamp_st_type st_ff;
  fai_lamp_st_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (ch.code == fai_pkg::FN_OFF) begin
      nxt_st.lamp = 1'b0;
    end else if (ch.over_det) begin
      nxt_st.lamp = ch.blink;
    end else begin
      nxt_st.lamp = ch.open_det;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '{lamp: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ch.lamp = st_ff.lamp;
endmodule

// ### design/fai_top.sv
`timescale 1ns/1ps
module fai_top #(
  parameter int unsigned BLINK_CYC = fai_pkg::BLINK_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        prm_wr_i,
  input  wire logic        prm_rd_i,
  input  wire logic [3:0]  prm_addr_i,
  input  wire logic [7:0]  prm_data_i,
  output logic      [7:0]  prm_rdata_o,
  output logic             prm_busy_o,
  output logic             prm_err_o,
  output logic             nvm_rd_o,
  output logic             nvm_wr_o,
  output logic      [3:0]  nvm_addr_o,
  output logic      [7:0]  nvm_wdata_o,
  input  wire logic [7:0]  nvm_rdata_i,
  input  wire logic        smp_vld_i,
  input  wire logic [1:0]  smp_ch_i,
  input  wire logic [15:0] smp_val_i,
  input  wire logic [3:0]  open_pin_i,
  input  wire logic [3:0]  over_pin_i,
  input  wire logic        img_rd_i,
  input  wire logic [2:0]  img_addr_i,
  output logic      [7:0]  img_data_o,
  output logic      [3:0]  chan_on_o,
  output logic      [3:0]  channel_fault_lamp_o
);
  localparam logic [fai_pkg::BLINK_W-1:0] BLINK_TOP = fai_pkg::BLINK_W'(BLINK_CYC - 1);

  typedef struct packed {
    fai_pkg::fai_st_type                        st;
    logic [3:0]                                 idx;
    logic [fai_pkg::PRM_BYTES-1:0][7:0]         prm;
    logic [3:0]                                 open_s1;
    logic [3:0]                                 open_s2;
    logic [3:0]                                 over_s1;
    logic [3:0]                                 over_s2;
    logic [fai_pkg::BLINK_W-1:0]                blink_cnt;
    logic                                       blink;
    logic [7:0]                                 prm_rdata;
    logic                                       err;
    logic                                       nvm_wr;
    logic [3:0]                                 nvm_addr;
    logic [7:0]                                 nvm_wdata;
    logic [7:0]                                 img_data;
    logic [3:0]                                 chan_on;
  } fai_top_st_type;

  fai_top_st_type st_ff;
  fai_top_st_type nxt_st;

  logic [fai_pkg::NUM_CH-1:0][15:0] res_w;
  logic [fai_pkg::NUM_CH-1:0]       lamp_w;

  fai_ch_if ch_if [fai_pkg::NUM_CH] ();

  // one word and one independent code per channel
  for (genvar g = 0; g < fai_pkg::NUM_CH; g++) begin : g_ch
    assign ch_if[g].code     = st_ff.prm[g];
    assign ch_if[g].smp_vld  = smp_vld_i && (smp_ch_i == 2'(g));
    assign ch_if[g].smp      = smp_val_i;
    assign ch_if[g].open_det = st_ff.open_s2[g];
    assign ch_if[g].over_det = st_ff.over_s2[g];
    assign ch_if[g].blink    = st_ff.blink;
    assign res_w[g]          = ch_if[g].result;
    assign lamp_w[g]         = ch_if[g].lamp;

    fai_fmt u_fmt (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .ch     (ch_if[g])
    );

    fai_lamp u_lamp (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .ch     (ch_if[g])
    );
  end

  always_comb begin
    logic [7:0] cap;
    logic       fn_byte;
    logic       wr_addr_ok;
    logic       wr_keep;
    logic       wr_bad;
    cap        = '0;
    fn_byte    = 1'b0;
    wr_addr_ok = 1'b0;
    wr_keep    = 1'b0;
    wr_bad     = 1'b0;
    nxt_st  = st_ff;

    // pins are asynchronous to the module clock
    nxt_st.open_s1 = open_pin_i;
    nxt_st.open_s2 = st_ff.open_s1;
    nxt_st.over_s1 = over_pin_i;
    nxt_st.over_s2 = st_ff.over_s1;

    // flash rate for the overcurrent lamp
    if (st_ff.blink_cnt == BLINK_TOP) begin
      nxt_st.blink_cnt = '0;
      nxt_st.blink     = !st_ff.blink;
    end else begin
      nxt_st.blink_cnt = st_ff.blink_cnt + 1'b1;
    end

    nxt_st.err    = 1'b0;
    nxt_st.nvm_wr = 1'b0;

    case (st_ff.st)
      fai_pkg::FAI_ST_RD: begin
        nxt_st.st = fai_pkg::FAI_ST_CAP;
      end
      fai_pkg::FAI_ST_CAP: begin
        cap     = nvm_rdata_i;
        fn_byte = st_ff.idx <= fai_pkg::PRM_FN_LAST;
        // restore stored bytes, zero or an unlisted code keeps the default
        if (!fn_byte) begin
          nxt_st.prm[st_ff.idx] = cap;
        end else if (cap != fai_pkg::FN_KEEP && (fai_pkg::fai_fn_valid(cap) || cap == fai_pkg::FN_OFF)) begin
          nxt_st.prm[st_ff.idx] = cap;
        end
        if (st_ff.idx == fai_pkg::PRM_LAST) begin
          nxt_st.st  = fai_pkg::FAI_ST_RUN;
          nxt_st.idx = '0;
        end else begin
          nxt_st.st  = fai_pkg::FAI_ST_RD;
          nxt_st.idx = st_ff.idx + 1'b1;
        end
      end
      fai_pkg::FAI_ST_RUN: begin
        fn_byte    = prm_addr_i <= fai_pkg::PRM_FN_LAST;
        wr_addr_ok = prm_addr_i <= fai_pkg::PRM_LAST;
        // zero is a no-op on a function byte
        wr_keep    = fn_byte && prm_data_i == fai_pkg::FN_KEEP;
        // accept listed codes and off, flag the rest
        wr_bad     = fn_byte && !wr_keep && !fai_pkg::fai_fn_valid(prm_data_i) &&
                     prm_data_i != fai_pkg::FN_OFF;
        if (prm_wr_i) begin
          // refused writes change nothing but the error pulse
          if (!wr_addr_ok || wr_bad) begin
            nxt_st.err = 1'b1;
          end else if (!wr_keep) begin
            nxt_st.prm[prm_addr_i] = prm_data_i;
            nxt_st.nvm_wr          = 1'b1;
            nxt_st.nvm_addr        = prm_addr_i;
            nxt_st.nvm_wdata       = prm_data_i;
          end
        end
        // bytes past the end read as zero rather than aliasing
        if (prm_rd_i) begin
          case (prm_addr_i)
            4'h0:    nxt_st.prm_rdata = st_ff.prm[0];
            4'h1:    nxt_st.prm_rdata = st_ff.prm[1];
            4'h2:    nxt_st.prm_rdata = st_ff.prm[2];
            4'h3:    nxt_st.prm_rdata = st_ff.prm[3];
            4'h4:    nxt_st.prm_rdata = st_ff.prm[4];
            4'h5:    nxt_st.prm_rdata = st_ff.prm[5];
            4'h6:    nxt_st.prm_rdata = st_ff.prm[6];
            4'h7:    nxt_st.prm_rdata = st_ff.prm[7];
            4'h8:    nxt_st.prm_rdata = st_ff.prm[8];
            4'h9:    nxt_st.prm_rdata = st_ff.prm[9];
            default: nxt_st.prm_rdata = 8'h00;
          endcase
        end
      end
      default: begin
        nxt_st.st  = fai_pkg::FAI_ST_RD;
        nxt_st.idx = '0;
      end
    endcase

    // load cycles reuse the write address register as the read address
    if (nxt_st.st == fai_pkg::FAI_ST_RD) begin
      nxt_st.nvm_addr = nxt_st.idx;
    end

    for (int i = 0; i < fai_pkg::NUM_CH; i++) begin
      nxt_st.chan_on[i] = nxt_st.prm[i] != fai_pkg::FN_OFF;
    end

    if (img_rd_i) begin
      case (img_addr_i)
        3'h0:    nxt_st.img_data = res_w[0][15:8];
        3'h1:    nxt_st.img_data = res_w[0][7:0];
        3'h2:    nxt_st.img_data = res_w[1][15:8];
        3'h3:    nxt_st.img_data = res_w[1][7:0];
        3'h4:    nxt_st.img_data = res_w[2][15:8];
        3'h5:    nxt_st.img_data = res_w[2][7:0];
        3'h6:    nxt_st.img_data = res_w[3][15:8];
        3'h7:    nxt_st.img_data = res_w[3][7:0];
        default: nxt_st.img_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff.st        <= fai_pkg::FAI_ST_RD;
      st_ff.idx       <= 4'h0;
      // every channel starts on the 10 V range
      st_ff.prm[0]    <= fai_pkg::FN_DEFAULT;
      st_ff.prm[1]    <= fai_pkg::FN_DEFAULT;
      st_ff.prm[2]    <= fai_pkg::FN_DEFAULT;
      st_ff.prm[3]    <= fai_pkg::FN_DEFAULT;
      st_ff.prm[4]    <= 8'h00;
      st_ff.prm[5]    <= 8'h00;
      st_ff.prm[6]    <= 8'h00;
      st_ff.prm[7]    <= 8'h00;
      st_ff.prm[8]    <= 8'h00;
      st_ff.prm[9]    <= 8'h00;
      st_ff.open_s1   <= 4'h0;
      st_ff.open_s2   <= 4'h0;
      st_ff.over_s1   <= 4'h0;
      st_ff.over_s2   <= 4'h0;
      st_ff.blink_cnt <= fai_pkg::BLINK_RESET;
      st_ff.blink     <= 1'b0;
      st_ff.prm_rdata <= 8'h00;
      st_ff.err       <= 1'b0;
      st_ff.nvm_wr    <= 1'b0;
      st_ff.nvm_addr  <= 4'h0;
      st_ff.nvm_wdata <= 8'h00;
      st_ff.img_data  <= 8'h00;
      st_ff.chan_on   <= 4'hf;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prm_rdata_o          = st_ff.prm_rdata;
  assign prm_busy_o           = st_ff.st != fai_pkg::FAI_ST_RUN;
  assign prm_err_o            = st_ff.err;
  assign nvm_rd_o             = st_ff.st == fai_pkg::FAI_ST_RD;
  assign nvm_wr_o             = st_ff.nvm_wr;
  assign nvm_addr_o           = st_ff.nvm_addr;
  assign nvm_wdata_o          = st_ff.nvm_wdata;
  assign img_data_o           = st_ff.img_data;
  assign chan_on_o            = st_ff.chan_on;
  assign channel_fault_lamp_o = lamp_w;
endmodule

// ### tb/fai_nvm_model.sv
`timescale 1ns/1ps
module fai_nvm_model (
  input  wire logic       clk_i,
  input  wire logic       nvm_rd_i,
  input  wire logic       nvm_wr_i,
  input  wire logic [3:0] nvm_addr_i,
  input  wire logic [7:0] nvm_wdata_i,
  output logic      [7:0] nvm_rdata_o
);
  logic [7:0] mem [10];
  initial begin
    mem = '{8'h01, 8'h00, 8'h16, 8'hff, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    nvm_rdata_o = 8'h00;
  end
  always @(posedge clk_i) begin
    if (nvm_wr_i && nvm_addr_i <= 4'h9)
      mem[nvm_addr_i] <= nvm_wdata_i;
    // data only valid the cycle after a read; otherwise it wanders
    if (nvm_rd_i && nvm_addr_i <= 4'h9)
      nvm_rdata_o <= mem[nvm_addr_i];
    else
      nvm_rdata_o <= ~nvm_rdata_o;
  end
endmodule

// ### tb/fai_chk_properties.sv
`timescale 1ns/1ps
module fai_chk_properties #(
  parameter int unsigned BLINK_CYC = 8
) (
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic       prm_wr_i,
  input wire logic       prm_rd_i,
  input wire logic [3:0] prm_addr_i,
  input wire logic [7:0] prm_data_i,
  input wire logic [7:0] prm_rdata_o,
  input wire logic       prm_busy_o,
  input wire logic       prm_err_o,
  input wire logic       nvm_rd_o,
  input wire logic       nvm_wr_o,
  input wire logic [3:0] nvm_addr_o,
  input wire logic [7:0] nvm_wdata_o,
  input wire logic [3:0] open_pin_i,
  input wire logic [3:0] over_pin_i,
  input wire logic [3:0] chan_on_o,
  input wire logic [3:0] channel_fault_lamp_o
);
  // window only suits short blink periods as used in simulation
  localparam int LAMP_WIN = 40;
  wire logic wr_ok = prm_wr_i && !prm_busy_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_addr_refused: assert property (wr_ok && prm_addr_i > 4'h9 |=> prm_err_o && !nvm_wr_o)
    else $error("write above last byte not refused");
  chk_code_refused: assert property (wr_ok && prm_addr_i < 4'h4 &&
    prm_data_i inside {[8'h16:8'h17], [8'h1e:8'h26], [8'h2c:8'hfe]} |=> prm_err_o && !nvm_wr_o)
    else $error("unlisted code not refused");
  chk_keep_code: assert property (wr_ok && prm_addr_i < 4'h4 && prm_data_i == 8'h00 |=> !nvm_wr_o && !prm_err_o)
    else $error("keep code caused a store or error");
  chk_chan_off: assert property (wr_ok && prm_addr_i < 4'h4 && prm_data_i == 8'hff |=>
    !chan_on_o[$past(prm_addr_i[1:0])])
    else $error("channel still active after off code");
  chk_general_store: assert property (wr_ok && prm_addr_i > 4'h3 && prm_addr_i <= 4'h9 |=> nvm_wr_o &&
    nvm_addr_o == $past(prm_addr_i) && nvm_wdata_o == $past(prm_data_i))
    else $error("parameter byte not stored");
  chk_read_beyond: assert property (!prm_busy_o && prm_rd_i && prm_addr_i > 4'h9 |=> prm_rdata_o == 8'h00)
    else $error("read above last byte not zero");
  chk_restore_pace: assert property (prm_busy_o && nvm_rd_o |=> !nvm_rd_o)
    else $error("restore reads back to back");
  chk_open_steady: assert property ((open_pin_i[0] && !over_pin_i[0] && chan_on_o[0])[*4] |->
    channel_fault_lamp_o[0])
    else $error("lamp dark on open loop");
  chk_lamp_dark: assert property ((open_pin_i == 4'h0 && over_pin_i == 4'h0)[*4] |-> channel_fault_lamp_o == 4'h0)
    else $error("lamp lit without fault");
  chk_over_blink: assert property ((over_pin_i[0] && chan_on_o[0])[*4] |->
    ##[1:LAMP_WIN] channel_fault_lamp_o[0] != $past(channel_fault_lamp_o[0]))
    else $error("lamp not flashing on overcurrent");
  cover property (prm_err_o);
  cover property (nvm_wr_o);
  cover property (channel_fault_lamp_o[0] && over_pin_i[0]);
endmodule

bind fai_top fai_chk_properties #(.BLINK_CYC(BLINK_CYC)) chk_u (.*);

// ### tb/fai_top_tb_top.sv
`timescale 1ns/1ps
module fai_top_tb_top;
  logic        clk_i, nrst_i, prm_wr_i, prm_rd_i, smp_vld_i, img_rd_i;
  logic [3:0]  prm_addr_i, open_pin_i, over_pin_i, nvm_addr_o, chan_on_o, channel_fault_lamp_o;
  logic [7:0]  prm_data_i, prm_rdata_o, nvm_wdata_o, nvm_rdata_i, img_data_o;
  logic        prm_busy_o, prm_err_o, nvm_rd_o, nvm_wr_o;
  logic [1:0]  smp_ch_i;
  logic [15:0] smp_val_i;
  logic [2:0]  img_addr_i;
  int          mismatches, tests_run, cyc;
  fai_top #(.BLINK_CYC(8)) dut_u (.*);
  fai_nvm_model nvm_u (.clk_i(clk_i), .nvm_rd_i(nvm_rd_o), .nvm_wr_i(nvm_wr_o), .nvm_addr_i(nvm_addr_o),
    .nvm_wdata_i(nvm_wdata_o), .nvm_rdata_o(nvm_rdata_i));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic results();
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      results();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr_prm(input logic [3:0] a, input logic [7:0] d, input logic err);
    prm_wr_i = 1'b1;
    prm_addr_i = a;
    prm_data_i = d;
    tick(1);
    prm_wr_i = 1'b0;
    check({15'h0, prm_err_o}, {15'h0, err});
    tick(1);
  endtask
  task automatic rd_prm(input logic [3:0] a, input logic [7:0] exp);
    prm_rd_i = 1'b1;
    prm_addr_i = a;
    tick(1);
    prm_rd_i = 1'b0;
    check({8'h0, prm_rdata_o}, {8'h0, exp});
    tick(1);
  endtask
  task automatic smp_img(input logic [1:0] ch, input logic [15:0] v, output logic [15:0] w);
    smp_vld_i = 1'b1;
    smp_ch_i = ch;
    smp_val_i = v;
    tick(1);
    smp_vld_i = 1'b0;
    img_rd_i = 1'b1;
    img_addr_i = {ch, 1'b0};
    tick(1);
    img_addr_i = {ch, 1'b1};
    w[15:8] = img_data_o;
    tick(1);
    img_rd_i = 1'b0;
    w[7:0] = img_data_o;
    tick(1);
  endtask
  task automatic t_restore();
    rd_prm(4'h0, 8'h01);
    rd_prm(4'h1, 8'h28);
    rd_prm(4'h2, 8'h28);
    rd_prm(4'h3, 8'hff);
    rd_prm(4'h9, 8'h66);
    rd_prm(4'hc, 8'h00);
    check({12'h0, chan_on_o}, 16'h0007);
  endtask
  task automatic t_codes();
    logic [7:0] ok [6] = '{8'h04, 8'h0c, 8'h0f, 8'h15, 8'h1d, 8'h27};
    for (int i = 0; i < 6; i++) begin
      wr_prm(4'h1, ok[i], 1'b0);
      rd_prm(4'h1, ok[i]);
    end
    wr_prm(4'h1, 8'h16, 1'b1);
    wr_prm(4'h1, 8'h00, 1'b0);
    rd_prm(4'h1, 8'h27);
    wr_prm(4'ha, 8'h01, 1'b1);
    wr_prm(4'h5, 8'h5a, 1'b0);
    rd_prm(4'h5, 8'h5a);
  endtask
  task automatic t_format();
    logic [15:0] w;
    smp_img(2'd0, 16'hf830, w);
    check(w, 16'hf830);
    wr_prm(4'h1, 8'h05, 1'b0);
    smp_img(2'd1, 16'h8000, w);
    check(w, 16'h0000);
    smp_img(2'd2, 16'h8000, w);
    check(w, 16'h8001);
    wr_prm(4'h1, 8'h2b, 1'b0);
    smp_img(2'd1, 16'h9400, w);
    // one count of rounding allowed on the nominal magnitude
    check({w[15], 15'h0}, 16'h8000);
    check(16'(w[14:0] inside {15'h3fff, 15'h4000}), 16'h0001);
    smp_img(2'd3, 16'h1234, w);
    check(w, 16'h0000);
    wr_prm(4'h2, 8'hff, 1'b0);
    check({12'h0, chan_on_o}, 16'h0003);
    smp_img(2'd0, 16'h0123, w);
    check(w, 16'h0123);
    wr_prm(4'h2, 8'h28, 1'b0);
  endtask
  task automatic t_lamps();
    int n;
    logic prev;
    open_pin_i = 4'h9;
    tick(6);
    check({12'h0, channel_fault_lamp_o}, 16'h0001);
    over_pin_i = 4'h1;
    n = 0;
    prev = channel_fault_lamp_o[0];
    repeat (40) begin
      tick(1);
      if (channel_fault_lamp_o[0] !== prev)
        n++;
      prev = channel_fault_lamp_o[0];
    end
    check(16'(n >= 3), 16'h0001);
    open_pin_i = 4'h0;
    over_pin_i = 4'h0;
    tick(6);
    check({12'h0, channel_fault_lamp_o}, 16'h0000);
  endtask
  task automatic t_persist();
    nrst_i = 1'b0;
    tick(12);
    nrst_i = 1'b1;
    // a write during restore must vanish silently
    wr_prm(4'h1, 8'h09, 1'b0);
    tick(22);
    rd_prm(4'h1, 8'h2b);
    rd_prm(4'h2, 8'h28);
    rd_prm(4'h5, 8'h5a);
  endtask
  initial begin
    {nrst_i, prm_wr_i, prm_rd_i, smp_vld_i, img_rd_i} = 5'h00;
    {prm_addr_i, open_pin_i, over_pin_i, prm_data_i} = 20'h00000;
    {smp_ch_i, smp_val_i, img_addr_i} = 21'h000000;
    {mismatches, tests_run, cyc} = '0;
    tick(12);
    nrst_i = 1'b1;
    tick(22);
    t_restore();
    t_codes();
    t_format();
    t_lamps();
    t_persist();
    results();
  end
endmodule
